// ==== rtl/imu_sensor_data_registers.sv ====
// Sensor data register group: latest raw and calibrated sensor axes,
// read by the host through a simple one-word read port.
// Assumes sample strobes and calibration inputs are on clk already.
//
// Contract
// RULE1: Keep raw accel Z, low half reserved
// RULE2: Keep raw field X and Y unchanged
// RULE3: Keep raw field Z, low half reserved
// RULE4: Rate: subtract bias, then multiply matrix
// RULE5: Processed axes presented as 16-bit integers
// RULE6: Rate step is 0.0610352 deg/s
// RULE7: Accel: subtract bias, then apply matrix
// RULE8: Accel step is 0.000183105 g
// RULE9: Field: subtract bias, then multiply matrix
// RULE10: Field step is 0.000305176 of norm
// RULE11: Pair registers: X upper, Y lower
// RULE12: Single registers: Z upper, lower reserved
// RULE13: Both halves of a pair update together
`timescale 1ns/1ns

module imu_sensor_data_registers (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire imu_data_pkg::sens_in_t rate_in,
   input  wire imu_data_pkg::sens_in_t accel_in,
   input  wire imu_data_pkg::sens_in_t field_in,
   input  wire logic                   rd_en,
   input  wire logic [7:0]             rd_addr,
   output logic                        rd_valid,
   output logic                        rd_err,
   output logic [31:0]                 rd_data
);
   import imu_data_pkg::*;

   // -------------------------------------------------------------
   // Calibration arithmetic
   // -------------------------------------------------------------

   // One output axis: row dot (raw - bias), rescaled and saturated.
   // Fixed point with wide guard bits stands in for the float path;
   // the matrix row carries the per-step scale of the sensor.
   function automatic logic [15:0] cal_axis(input vec3_t raw,
                                            input vec3_t bias,
                                            input vec3_t row);
      logic signed [16:0] dx;
      logic signed [16:0] dy;
      logic signed [16:0] dz;
      logic signed [34:0] acc;
      logic signed [20:0] sh;
      dx  = $signed({raw.x[15], raw.x}) - $signed({bias.x[15], bias.x});
      dy  = $signed({raw.y[15], raw.y}) - $signed({bias.y[15], bias.y});
      dz  = $signed({raw.z[15], raw.z}) - $signed({bias.z[15], bias.z});
      acc = 35'(dx * $signed(row.x)) + 35'(dy * $signed(row.y))
          + 35'(dz * $signed(row.z));
      sh  = 21'(acc >>> CAL_FRAC);
      // Clamp to the 16-bit two's complement range
      if (sh > 21'sd32767) begin
         cal_axis = 16'h7fff;
      end else if (sh < -21'sd32768) begin
         cal_axis = 16'h8000;
      end else begin
         cal_axis = sh[15:0];
      end
   endfunction : cal_axis

   // -------------------------------------------------------------
   // Per-sensor calibration
   // -------------------------------------------------------------

   sens_in_t sens     [SENS_N];  // Sensors gathered by index
   vec3_t    cal_vec  [SENS_N];  // Calibrated vector of each sensor
   vec3_t    raw_r    [SENS_N];  // Latest raw vector
   vec3_t    raw_nxt  [SENS_N];
   vec3_t    proc_r   [SENS_N];  // Latest calibrated vector
   vec3_t    proc_nxt [SENS_N];

   assign sens[SENS_RATE]  = rate_in;
   assign sens[SENS_ACCEL] = accel_in;
   assign sens[SENS_FIELD] = field_in;

   // Same bias-then-matrix path for rate, accel and field
   generate
      for (genvar g = 0; g < SENS_N; g++) begin : g_cal
         // Bias removed first, then the matrix row [RULE4] [RULE7] [RULE9]
         assign cal_vec[g].x = cal_axis(sens[g].raw, sens[g].bias,
                                        sens[g].row_x);
         assign cal_vec[g].y = cal_axis(sens[g].raw, sens[g].bias,
                                        sens[g].row_y);
         assign cal_vec[g].z = cal_axis(sens[g].raw, sens[g].bias,
                                        sens[g].row_z);
      end
   endgenerate

   // -------------------------------------------------------------
   // Sample store
   // -------------------------------------------------------------

   // Next values: a strobe loads the whole vector at once [RULE13]
   always_comb begin
      for (int i = 0; i < SENS_N; i++) begin
         raw_nxt[i]  = raw_r[i];
         proc_nxt[i] = proc_r[i];
         if (sens[i].strobe) begin
            // Raw sample kept as delivered [RULE1] [RULE2] [RULE3]
            raw_nxt[i]  = sens[i].raw;
            // Calibrated sample as 16-bit integers [RULE5]
            proc_nxt[i] = cal_vec[i];
         end
      end
   end

   // Store registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < SENS_N; i++) begin
            raw_r[i]  <= '{x: AXIS_RST, y: AXIS_RST, z: AXIS_RST};
            proc_r[i] <= '{x: AXIS_RST, y: AXIS_RST, z: AXIS_RST};
         end
      end else begin
         for (int i = 0; i < SENS_N; i++) begin
            raw_r[i]  <= raw_nxt[i];
            proc_r[i] <= proc_nxt[i];
         end
      end
   end

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------

   logic        rd_valid_r;   // Answer strobe
   logic        rd_valid_nxt;
   logic        rd_err_r;     // Address hit no register
   logic        rd_err_nxt;
   logic [31:0] rd_data_r;    // Answer word
   logic [31:0] rd_data_nxt;
   logic [31:0] word;         // Decoded word for rd_addr
   logic        hit;          // rd_addr is mapped

   // Address decode and word packing
   always_comb begin
      hit  = 1'b1;
      word = UNMAPPED_RD;
      case (rd_addr)
         // Single axis: Z high, reserved low [RULE12]
         ACCEL_RAW_Z_AXIS:
            word = {raw_r[SENS_ACCEL].z, RESERVED_RD};       // [RULE1]
         // Pair: X high, Y low [RULE11]
         FIELD_RAW_X_Y_AXES:
            word = {raw_r[SENS_FIELD].x, raw_r[SENS_FIELD].y}; // [RULE2]
         FIELD_RAW_Z_AXIS:
            word = {raw_r[SENS_FIELD].z, RESERVED_RD};       // [RULE3]
         // Rate step fixed by the rate matrix [RULE6]
         RATE_PROCESSED_X_Y_AXES:
            word = {proc_r[SENS_RATE].x, proc_r[SENS_RATE].y}; // [RULE11]
         RATE_PROCESSED_Z_AXIS:
            word = {proc_r[SENS_RATE].z, RESERVED_RD};        // [RULE12]
         // Accel step fixed by the accel matrix [RULE8]
         ACCEL_PROCESSED_X_Y_AXES:
            word = {proc_r[SENS_ACCEL].x, proc_r[SENS_ACCEL].y};
         ACCEL_PROCESSED_Z_AXIS:
            word = {proc_r[SENS_ACCEL].z, RESERVED_RD};       // [RULE12]
         // Unit-norm field, step fixed by the field matrix [RULE10]
         FIELD_PROCESSED_X_Y_AXES:
            word = {proc_r[SENS_FIELD].x, proc_r[SENS_FIELD].y};
         // Anything else reads zero and flags an error
         default: begin
            hit  = 1'b0;
            word = UNMAPPED_RD;
         end
      endcase
   end

   // Next values of the answer
   always_comb begin
      rd_valid_nxt = rd_en;
      rd_err_nxt   = rd_en & ~hit;
      rd_data_nxt  = rd_data_r;
      if (rd_en) begin
         // One read captures both halves in one edge [RULE13]
         rd_data_nxt = word;
      end
   end

   // Answer registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_valid_r <= 1'b0;
         rd_err_r   <= 1'b0;
         rd_data_r  <= UNMAPPED_RD;
      end else begin
         rd_valid_r <= rd_valid_nxt;
         rd_err_r   <= rd_err_nxt;
         rd_data_r  <= rd_data_nxt;
      end
   end

   assign rd_valid = rd_valid_r;
   assign rd_err   = rd_err_r;
   assign rd_data  = rd_data_r;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Raw accel Z read shows stored Z over a zero low half
   a_accz_layout: assert property ( // [RULE1]
      rd_en && rd_addr == ACCEL_RAW_Z_AXIS |=>
         rd_data == {$past(raw_r[SENS_ACCEL].z), RESERVED_RD})
      else $error("raw accel Z word wrong");

   // Raw field pair taken unchanged from a strobe
   a_field_raw: assert property ( // [RULE2]
      field_in.strobe ##1 (!field_in.strobe && rd_en
         && rd_addr == FIELD_RAW_X_Y_AXES) |=>
         rd_data == {$past(field_in.raw.x, 2), $past(field_in.raw.y, 2)})
      else $error("raw field pair not as sampled");

   // Raw field Z low half reserved
   a_fieldz_rsv: assert property ( // [RULE3]
      rd_en && rd_addr == FIELD_RAW_Z_AXIS |=>
         rd_data[15:0] == RESERVED_RD && !rd_err)
      else $error("raw field Z low half not zero");

   // Rate: zero bias, unit first row gives the raw X back
   a_rate_ident: assert property ( // [RULE4]
      rate_in.strobe && rate_in.bias == '0
      && rate_in.row_x == {16'h4000, 16'h0000, 16'h0000} |=>
         proc_r[SENS_RATE].x == $past(rate_in.raw.x))
      else $error("rate identity path wrong");

   // Accel: raw equal to bias gives zero on every axis
   a_accel_bias: assert property ( // [RULE7]
      accel_in.strobe && accel_in.raw == accel_in.bias |=>
         proc_r[SENS_ACCEL] == '0)
      else $error("accel bias not removed");

   // Field pair read gives stored calibrated X and Y
   a_field_proc: assert property ( // [RULE9]
      rd_en && rd_addr == FIELD_PROCESSED_X_Y_AXES |=>
         rd_data == {$past(proc_r[SENS_FIELD].x),
                     $past(proc_r[SENS_FIELD].y)})
      else $error("field pair word wrong");

   // Rate Z single-axis layout
   a_ratez_layout: assert property ( // [RULE12]
      rd_en && rd_addr == RATE_PROCESSED_Z_AXIS |=>
         rd_data == {$past(proc_r[SENS_RATE].z), RESERVED_RD})
      else $error("rate Z word wrong");

   // Both halves of the calibrated accel pair change only on its strobe
   a_pair_atomic: assert property ( // [RULE13]
      !accel_in.strobe |=> $stable(proc_r[SENS_ACCEL]))
      else $error("accel vector changed without strobe");

   // Raw field store changes only on its strobe
   a_raw_atomic: assert property ( // [RULE13]
      !field_in.strobe |=> $stable(raw_r[SENS_FIELD]))
      else $error("raw field vector changed without strobe");

   // Raw field pair read shows the stored X over the stored Y
   a_fieldxy_layout: assert property ( // [RULE2]
      rd_en && rd_addr == FIELD_RAW_X_Y_AXES |=>
         rd_data == {$past(raw_r[SENS_FIELD].x),
                     $past(raw_r[SENS_FIELD].y)})
      else $error("raw field pair word wrong");

   // Raw field Z read shows the stored Z over a zero low half
   a_fieldz_word: assert property ( // [RULE3]
      rd_en && rd_addr == FIELD_RAW_Z_AXIS |=>
         rd_data == {$past(raw_r[SENS_FIELD].z), RESERVED_RD})
      else $error("raw field Z word wrong");

   // Field: zero bias, unit first row gives the raw X back
   a_field_ident: assert property ( // [RULE9]
      field_in.strobe && field_in.bias == '0
      && field_in.row_x == {16'h4000, 16'h0000, 16'h0000} |=>
         proc_r[SENS_FIELD].x == $past(field_in.raw.x))
      else $error("field identity path wrong");

   // Rate pair read gives stored calibrated X and Y
   a_rate_pair: assert property ( // [RULE11]
      rd_en && rd_addr == RATE_PROCESSED_X_Y_AXES |=>
         rd_data == {$past(proc_r[SENS_RATE].x),
                     $past(proc_r[SENS_RATE].y)})
      else $error("rate pair word wrong");

   // Accel pair read gives stored calibrated X and Y
   a_accel_pair: assert property ( // [RULE11]
      rd_en && rd_addr == ACCEL_PROCESSED_X_Y_AXES |=>
         rd_data == {$past(proc_r[SENS_ACCEL].x),
                     $past(proc_r[SENS_ACCEL].y)})
      else $error("accel pair word wrong");

   // Accel Z single-axis layout
   a_accelz_layout: assert property ( // [RULE12]
      rd_en && rd_addr == ACCEL_PROCESSED_Z_AXIS |=>
         rd_data == {$past(proc_r[SENS_ACCEL].z), RESERVED_RD})
      else $error("accel Z word wrong");

   // Answer one cycle after the request, errors only off the map
   a_read_answer: assert property ( // [RULE11]
      rd_en |=> rd_valid ##0 (rd_err == ($past(hit) == 1'b0)))
      else $error("read answer timing or error flag wrong");

   // Scenarios worth seeing
   c_rate_strobe: cover property (rate_in.strobe ##1 rd_en
      && rd_addr == RATE_PROCESSED_X_Y_AXES);
   c_unmapped: cover property (rd_en && !hit);
   c_back2back: cover property (rd_en ##1 rd_en);
   c_strobe_read: cover property (field_in.strobe && rd_en
      && rd_addr == FIELD_RAW_X_Y_AXES);
   c_rate_ident: cover property (rate_in.strobe && rate_in.bias == '0);

endmodule : imu_sensor_data_registers

// ==== rtl/imu_data_pkg.sv ====
// Package for the sensor data register group: register offsets,
// field layout, reset values and the fixed-point calibration format.
// Assumes a host-side serial engine turns frames into register reads.
package imu_data_pkg;

   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ACCEL_RAW_Z_AXIS         = 8'h59;
   localparam logic [7:0] FIELD_RAW_X_Y_AXES       = 8'h5a;
   localparam logic [7:0] FIELD_RAW_Z_AXIS         = 8'h5b;
   localparam logic [7:0] RATE_PROCESSED_X_Y_AXES  = 8'h5c;
   localparam logic [7:0] RATE_PROCESSED_Z_AXIS    = 8'h5d;
   localparam logic [7:0] ACCEL_PROCESSED_X_Y_AXES = 8'h5e;
   localparam logic [7:0] ACCEL_PROCESSED_Z_AXIS   = 8'h5f;
   localparam logic [7:0] FIELD_PROCESSED_X_Y_AXES = 8'h60;

   // -------------------------------------------------------------
   // Field layout and reset values
   // -------------------------------------------------------------
   localparam int          HI_LSB      = 16;     // X or Z half
   localparam int          LO_LSB      = 0;      // Y or reserved half
   localparam logic [15:0] RESERVED_RD = 16'h0000;
   localparam logic [15:0] AXIS_RST    = 16'h0000;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   // -------------------------------------------------------------
   // Calibration format and scale of one output step
   // -------------------------------------------------------------
   localparam int  CAL_FRAC        = 14;   // Matrix entries are Q2.14
   localparam real RATE_LSB_DPS    = 0.0610352;
   localparam real ACCEL_LSB_G     = 0.000183105;
   localparam real FIELD_LSB_NORM  = 0.000305176;

   // Sensor index
   localparam int SENS_RATE  = 0;
   localparam int SENS_ACCEL = 1;
   localparam int SENS_FIELD = 2;
   localparam int SENS_N     = 3;

   // Three 16-bit two's complement axes
   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } vec3_t;

   // One sensor's sample strobe, raw vector and calibration set
   typedef struct packed {
      logic  strobe;
      vec3_t raw;
      vec3_t bias;
      vec3_t row_x;
      vec3_t row_y;
      vec3_t row_z;
   } sens_in_t;

endpackage : imu_data_pkg

// ==== dv/host_reader.sv ====
// Host model: issues single register reads on the one-word read port.
// Assumes the bench calls read() and that clk is free running.
`timescale 1ns/1ns

module host_reader (
   input  wire logic        clk,
   output logic             rd_en,
   output logic [7:0]       rd_addr,
   input  wire logic        rd_valid,
   input  wire logic        rd_err,
   input  wire logic [31:0] rd_data
);
   // ----------------------------------------------------------
   // Idle state: no request, address parked
   // ----------------------------------------------------------
   initial begin
      rd_en   = 1'b0;
      rd_addr = 8'h00;
   end

   // One read: request on a falling edge, taken at the next rise,
   // answer sampled at the following fall; address inverted when released
   task automatic read(input  logic [7:0]  a,
                       output logic [31:0] d,
                       output logic        e,
                       output logic        ok);
      @(negedge clk);
      rd_en   = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_en   = 1'b0;
      rd_addr = ~a;
      ok      = rd_valid;
      d       = rd_data;
      e       = rd_err;
   endtask : read
endmodule : host_reader

// ==== dv/tb_imu_sensor_data_registers.sv ====
// Testbench: loads sensor samples, reads every register and compares.
// Assumes host_reader and the design package are compiled first.
`timescale 1ns/1ns

module tb_imu_sensor_data_registers;
   import imu_data_pkg::*;
   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic        clk;
   logic        rstn;
   sens_in_t    si [3];       // Rate, accel, field sample inputs
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic        rd_valid;
   logic        rd_err;
   logic [31:0] rd_data;
   int          err_total;
   int          n_compared;
   int          cyc;
   vec3_t       pr [3];       // Expected processed vectors

   imu_sensor_data_registers imu_sensor_data_registers_inst (
      .clk(clk), .rstn(rstn), .rate_in(si[0]), .accel_in(si[1]),
      .field_in(si[2]), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

   host_reader host_reader_inst (
      .clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

   // ----------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Read one register and compare word, valid and error flag
   task automatic rdchk(logic [7:0] a, logic [31:0] exp, logic xe);
      logic [31:0] d;
      logic        e;
      logic        ok;
      host_reader_inst.read(a, d, e, ok);
      chk({31'h0, ok}, 32'h1, "valid");
      chk(d, exp, "data");
      chk({31'h0, e}, {31'h0, xe}, "err");
   endtask : rdchk

   // Present one sample with its calibration for one cycle
   task automatic load(int s, vec3_t raw, vec3_t b, vec3_t rx,
                       vec3_t ry, vec3_t rz);
      @(negedge clk);
      si[s] = '{1'b1, raw, b, rx, ry, rz};
      @(negedge clk);
      si[s].strobe = 1'b0;
   endtask : load

   // Floor of row dot (raw - bias) in Q2.14, saturated to 16 bits
   function automatic logic [15:0] dot(vec3_t r, vec3_t b, vec3_t m);
      longint acc;
      acc = longint'($signed(m.x)) * (longint'($signed(r.x)) - $signed(b.x))
          + longint'($signed(m.y)) * (longint'($signed(r.y)) - $signed(b.y))
          + longint'($signed(m.z)) * (longint'($signed(r.z)) - $signed(b.z));
      acc = acc >>> CAL_FRAC;
      if (acc > 32767) return 16'h7fff;
      if (acc < -32768) return 16'h8000;
      return acc[15:0];
   endfunction : dot

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      rstn = 1'b0;
      for (int i = 0; i < 3; i++) begin
         si[i] = '0;
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      // Reset values, then unmapped places on both sides of the map
      for (int a = 8'h59; a <= 8'h60; a++) begin
         rdchk(a[7:0], 32'h0, 1'b0);
      end
      rdchk(8'h58, UNMAPPED_RD, 1'b1);
      rdchk(8'h61, UNMAPPED_RD, 1'b1);
      $display("test reset_and_map done");
      // Rate: permuted rows and negative unit, saturates high
      load(0, '{16'h0100, 16'hfff0, 16'h8000}, '{16'h1, 16'h2, 16'h3},
           '{16'h0, 16'h4000, 16'h0}, '{16'h4000, 16'h0, 16'h0},
           '{16'h0, 16'h0, 16'hc000});
      // Accel: half gain on the diagonal, floors odd values
      load(1, '{16'h1111, 16'h2222, 16'h8001}, '{16'h0, 16'h0, 16'h0},
           '{16'h2000, 16'h0, 16'h0}, '{16'h0, 16'h2000, 16'h0},
           '{16'h0, 16'h0, 16'h2000});
      // Field: identity with bias, y saturates low
      load(2, '{16'h7fff, 16'h8000, 16'h0123}, '{16'h10, 16'h20, 16'h30},
           '{16'h4000, 16'h0, 16'h0}, '{16'h0, 16'h4000, 16'h0},
           '{16'h0, 16'h0, 16'h4000});
      for (int i = 0; i < 3; i++) begin
         pr[i] = '{dot(si[i].raw, si[i].bias, si[i].row_x),
                   dot(si[i].raw, si[i].bias, si[i].row_y),
                   dot(si[i].raw, si[i].bias, si[i].row_z)};
      end
      rdchk(8'h59, {16'h8001, RESERVED_RD}, 1'b0);
      rdchk(8'h5a, {16'h7fff, 16'h8000}, 1'b0);
      rdchk(8'h5b, {16'h0123, RESERVED_RD}, 1'b0);
      rdchk(8'h5c, {pr[0].x, pr[0].y}, 1'b0);
      rdchk(8'h5d, {pr[0].z, RESERVED_RD}, 1'b0);
      rdchk(8'h5e, {pr[1].x, pr[1].y}, 1'b0);
      rdchk(8'h5f, {pr[1].z, RESERVED_RD}, 1'b0);
      rdchk(8'h60, {pr[2].x, pr[2].y}, 1'b0);
      $display("test load_and_read done");
      // New field sample: a read at the strobe edge sees the old pair,
      // later reads see both new halves together
      fork
         load(2, '{16'hff00, 16'h0042, 16'h0}, '{16'h0, 16'h0, 16'h0},
              '{16'h4000, 16'h0, 16'h0}, '{16'h0, 16'h4000, 16'h0},
              '{16'h0, 16'h0, 16'h4000});
         rdchk(8'h5a, {16'h7fff, 16'h8000}, 1'b0);
      join
      rdchk(8'h5a, {16'hff00, 16'h0042}, 1'b0);
      rdchk(8'h60, {16'hff00, 16'h0042}, 1'b0);
      // Read taken on the edge right after the strobe sees the new pair
      fork
         load(2, '{16'h0200, 16'hfe00, 16'h0}, '{16'h0, 16'h0, 16'h0},
              '{16'h4000, 16'h0, 16'h0}, '{16'h0, 16'h4000, 16'h0},
              '{16'h0, 16'h0, 16'h4000});
         begin
            @(negedge clk);
            rdchk(8'h5a, {16'h0200, 16'hfe00}, 1'b0);
         end
      join
      $display("test pair_update done");
      // Rate: zero bias and unit matrix hand the raw vector through
      fork
         load(0, '{16'h1234, 16'hedcc, 16'h0007}, '{16'h0, 16'h0, 16'h0},
              '{16'h4000, 16'h0, 16'h0}, '{16'h0, 16'h4000, 16'h0},
              '{16'h0, 16'h0, 16'h4000});
         begin
            @(negedge clk);
            rdchk(8'h5c, {16'h1234, 16'hedcc}, 1'b0);
         end
      join
      rdchk(8'h5d, {16'h0007, RESERVED_RD}, 1'b0);
      // Accel: raw equal to bias leaves zero whatever the matrix
      load(1, '{16'h0500, 16'hfb00, 16'h0100},
           '{16'h0500, 16'hfb00, 16'h0100},
           '{16'h2000, 16'h4000, 16'h0}, '{16'h0, 16'hc000, 16'h0},
           '{16'h1000, 16'h0, 16'h4000});
      rdchk(8'h5e, 32'h0, 1'b0);
      rdchk(8'h5f, 32'h0, 1'b0);
      $display("test ident_and_bias done");
      // Reset in mid-run clears the stored axes
      @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      rdchk(8'h5a, 32'h0, 1'b0);
      $display("test second_reset done");
      tally_and_finish();
   end
endmodule : tb_imu_sensor_data_registers
